// ==== core/battery_monitor_link.sv ====
`timescale 1ns/1ps
module battery_monitor_link #(
  parameter int CLK_LOW_CYCLES = bmon_pkg::CLK_LOW_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input bmon_pkg::reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  // Single wire pin
  input wire logic wire_in,
  output logic wire_out,
  output logic wire_oe,
  // Battery bus engine
  input wire logic bus_clk_in,
  input wire logic target_done_pulse,
  input wire logic arb_loss_pulse,
  input wire logic missing_ack_pulse,
  input wire logic stop_sent_pulse,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Interrupt
  output logic combined_irq_out
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  if (CLK_LOW_CYCLES < 2 || CLK_LOW_CYCLES >= (1 << 20)) begin : g_bad
    $error("battery_monitor_link: clock low count must fit 20 bits");
  end

  function automatic logic at(input bmon_pkg::reg_req_type r, input logic [7:0] ofs);
    return r.addr == ofs;
  endfunction

  logic rst_meta_q;
  logic rst_core_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_core_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_core_n <= rst_meta_q;
    end
  end

  bmon_pkg::core_state_type s;
  bmon_pkg::core_state_type d;
  logic tick;
  logic rx_full;
  logic rx_empty;
  logic [7:0] rx_head;
  logic [CW-1:0] rx_count;
  logic tx_full;
  logic tx_empty;
  logic [CW-1:0] tx_count;
  logic fifo_single;
  logic rx_pop;
  logic tx_push;
  logic receive_level_irq;
  logic transmit_level_irq;
  logic [7:0] braw_full;
  logic [7:0] bmasked;
  logic [2:0] wmasked;

  ref_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_core_n),
    .tick(tick)
  );

  assign fifo_single = !s.bctrl[bmon_pkg::BB_POS_FIFO_EN];
  assign rx_pop = reg_req.rd && at(reg_req, bmon_pkg::OFS_BB_DATA);
  assign tx_push = reg_req.wr && at(reg_req, bmon_pkg::OFS_BB_DATA);
  assign rx_ready = !rx_full;
  assign tx_valid = !tx_empty;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_core_n),
    .flush(missing_ack_pulse),
    .single(fifo_single),
    .push(rx_valid),
    .push_data(rx_byte),
    .full(rx_full),
    .pop(rx_pop),
    .head(rx_head),
    .empty(rx_empty),
    .count(rx_count)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_core_n),
    .flush(missing_ack_pulse),
    .single(fifo_single),
    .push(tx_push),
    .push_data(reg_req.wdata[7:0]),
    .full(tx_full),
    .pop(tx_ready),
    .head(tx_byte),
    .empty(tx_empty),
    .count(tx_count)
  );

  assign receive_level_irq = fifo_single ? !rx_empty : rx_count >= CW'(FIFO_DEPTH / 2);
  assign transmit_level_irq = fifo_single ? tx_empty : tx_count <= CW'(FIFO_DEPTH / 2);
  assign braw_full = {transmit_level_irq, receive_level_irq, s.braw};
  assign bmasked = braw_full & s.bien;
  assign wmasked = s.wraw & s.wien;
  // The combined line is a level built from registered state only.
  assign combined_irq_out = |bmasked;
  assign reg_rdata = s.rdata;
  assign wire_out = s.out_lvl;
  assign wire_oe = s.out_en;

  always_comb begin
    logic pol;
    logic en;
    logic busy;
    logic line;
    logic start_edge;
    logic part_done;
    logic [15:0] limit;
    logic [5:0] len;
    logic [31:0] w;
    d = s;
    pol = s.wctrl[bmon_pkg::POS_POL];
    en = s.wctrl[bmon_pkg::POS_ENABLE];
    busy = s.phase != bmon_pkg::W_IDLE;
    line = s.line_sync[1];
    w = reg_req.wdata;
    len = s.rx_mode ? s.wctrl[bmon_pkg::POS_RLEN +: 6] : s.wctrl[bmon_pkg::POS_WLEN +: 6];
    // Start edge is falling at normal polarity and rising when flipped.
    start_edge = (s.line_sync[2] != pol) && (line == pol);
    d.line_sync = {s.line_sync[1:0], wire_in};
    d.clk_sync = {s.clk_sync[0], bus_clk_in};
    d.rdata = 32'h0000_0000;
    if (s.phase == bmon_pkg::W_BREAK) begin
      limit = s.wbrk[15:0];
    end else if (s.phase == bmon_pkg::W_RECOVER) begin
      limit = s.wbrk[31:16];
    end else begin
      limit = s.wbit[15:0];
    end
    part_done = tick && s.partcnt == limit;
    if (tick) begin
      d.partcnt = part_done ? 16'h0000 : s.partcnt + 16'h0001;
    end

    // Register writes and clears come first so that hardware sets below win.
    if (reg_req.wr) begin
      case (reg_req.addr)
        bmon_pkg::OFS_WIRE_DATA: begin
          if (busy) begin
            d.tef = 1'b1;
          end else begin
            d.wdata = w;
            if (en) begin
              d.shift = s.wctrl[bmon_pkg::POS_FLIP] ? ~w : w;
              d.phase = bmon_pkg::W_START;
              d.rx_mode = 1'b0;
              d.bitcnt = 6'h00;
              d.partcnt = 16'h0000;
              d.col = 1'b0;
            end
          end
        end
        bmon_pkg::OFS_WIRE_CTRL: d.wctrl = w & bmon_pkg::WIRE_CTRL_BITS;
        bmon_pkg::OFS_WIRE_RAW: begin
          d.wraw[bmon_pkg::WIRQ_BREAK] = s.wraw[bmon_pkg::WIRQ_BREAK] & ~w[bmon_pkg::WIRQ_BREAK];
          d.wraw[bmon_pkg::WIRQ_WORD_OUT] = s.wraw[bmon_pkg::WIRQ_WORD_OUT] & ~w[bmon_pkg::WIRQ_WORD_OUT];
          d.txf = s.txf & ~w[bmon_pkg::WIRQ_WORD_OUT];
        end
        bmon_pkg::OFS_WIRE_IEN: d.wien = w[2:0];
        bmon_pkg::OFS_WIRE_BIT: d.wbit = {16'h0000, w[15:0]};
        bmon_pkg::OFS_WIRE_BRK: d.wbrk = w;
        bmon_pkg::OFS_BB_CTRL: d.bctrl = w;
        bmon_pkg::OFS_BB_COUNT: d.bcount = w;
        bmon_pkg::OFS_BB_RAW: d.braw[4:0] = s.braw[4:0] & ~(w[4:0] & bmon_pkg::BIRQ_EOI_BITS);
        bmon_pkg::OFS_BB_IEN: d.bien = w[7:0];
        default: ;
      endcase
    end
    if (reg_req.rd && at(reg_req, bmon_pkg::OFS_WIRE_DATA)) begin
      d.wraw[bmon_pkg::WIRQ_WORD_IN] = 1'b0;
      d.rxf = 1'b0;
    end

    // Wire sequencer.
    case (s.phase)
      bmon_pkg::W_IDLE: begin
        if (en && s.wctrl[bmon_pkg::POS_BREAK]) begin
          d.phase = bmon_pkg::W_BREAK;
          d.wctrl[bmon_pkg::POS_BREAK] = 1'b0;
          d.partcnt = 16'h0000;
          d.tef = 1'b0;
          d.col = 1'b0;
          d.brf = 1'b0;
        end else if (en && start_edge) begin
          d.phase = bmon_pkg::W_START;
          d.rx_mode = 1'b1;
          d.bitcnt = 6'h00;
          d.shift = 32'h0000_0000;
          d.partcnt = 16'h0000;
          d.col = 1'b0;
        end
      end
      bmon_pkg::W_START: begin
        if (part_done) begin
          d.phase = bmon_pkg::W_DATA;
        end
      end
      bmon_pkg::W_DATA: begin
        // The far end's bit is sampled in the middle of the data part.
        if (s.rx_mode && tick && s.partcnt == (s.wbit[15:0] >> 1)) begin
          d.shift[s.bitcnt[4:0]] = line ^ pol;
        end
        if (part_done) begin
          d.phase = bmon_pkg::W_STOP;
        end
      end
      bmon_pkg::W_STOP: begin
        if (!s.rx_mode && start_edge) begin
          d.col = 1'b1;
        end
        if (part_done) begin
          if ({1'b0, s.bitcnt} + 7'h01 >= {1'b0, len} || s.bitcnt == 6'h1F) begin
            d.phase = bmon_pkg::W_IDLE;
            if (s.rx_mode) begin
              d.wdata = s.wctrl[bmon_pkg::POS_FLIP] ? s.shift ^ lowmask(len) : s.shift;
              d.wraw[bmon_pkg::WIRQ_WORD_IN] = 1'b1;
              d.rxf = 1'b1;
            end else begin
              d.wraw[bmon_pkg::WIRQ_WORD_OUT] = 1'b1;
              d.txf = 1'b1;
            end
          end else begin
            d.bitcnt = s.bitcnt + 6'h01;
            d.phase = bmon_pkg::W_START;
            if (!s.rx_mode) begin
              d.shift = s.shift >> 1;
            end
          end
        end
      end
      bmon_pkg::W_BREAK: begin
        if (part_done) begin
          d.phase = bmon_pkg::W_RECOVER;
        end
      end
      bmon_pkg::W_RECOVER: begin
        if (part_done) begin
          d.phase = bmon_pkg::W_IDLE;
          d.wraw[bmon_pkg::WIRQ_BREAK] = 1'b1;
          d.brf = 1'b1;
        end
      end
      default: d.phase = bmon_pkg::W_IDLE;
    endcase

    // Abort and disable force the phase to idle, including a start this cycle.
    if (s.wctrl[bmon_pkg::POS_ABORT] || !en) begin
      d.phase = bmon_pkg::W_IDLE;
      d.wctrl[bmon_pkg::POS_ABORT] = 1'b0;
    end
    d.out_en = d.phase != bmon_pkg::W_IDLE && !d.rx_mode;
    case (d.phase)
      bmon_pkg::W_START: d.out_lvl = pol;
      bmon_pkg::W_BREAK: d.out_lvl = pol;
      bmon_pkg::W_DATA: d.out_lvl = d.shift[0] ^ pol;
      default: d.out_lvl = ~pol;
    endcase

    // Battery bus receive timeout.
    if (rx_pop) begin
      d.braw[bmon_pkg::BIRQ_RX_TO] = 1'b0;
      d.to_run = 1'b0;
    end
    if (s.to_run) begin
      if (s.to_cnt == s.bctrl[bmon_pkg::BB_POS_TIMEOUT +: 16]) begin
        d.braw[bmon_pkg::BIRQ_RX_TO] = 1'b1;
        d.to_run = 1'b0;
      end else begin
        d.to_cnt = s.to_cnt + 16'h0001;
      end
    end
    if (rx_valid && !rx_full) begin
      d.to_run = 1'b1;
      d.to_cnt = 16'h0000;
    end

    // Clock low watchdog on the synchronised bus clock.
    if (!s.clk_sync[1]) begin
      if (s.low_cnt != 20'(CLK_LOW_CYCLES)) begin
        d.low_cnt = s.low_cnt + 20'h00001;
      end
      if (s.low_cnt == 20'(CLK_LOW_CYCLES - 1)) begin
        d.braw[bmon_pkg::BIRQ_CLK_LOW] = 1'b1;
      end
    end else begin
      d.low_cnt = 20'h00000;
    end
    if (target_done_pulse) d.braw[bmon_pkg::BIRQ_TARGET] = 1'b1;
    if (arb_loss_pulse) d.braw[bmon_pkg::BIRQ_ARB] = 1'b1;
    if (missing_ack_pulse) d.braw[bmon_pkg::BIRQ_ACK] = 1'b1;
    if (stop_sent_pulse) d.braw[bmon_pkg::BIRQ_INIT] = 1'b1;

    if (reg_req.rd) begin
      case (reg_req.addr)
        bmon_pkg::OFS_WIRE_DATA: d.rdata = s.wdata;
        bmon_pkg::OFS_WIRE_CTRL: d.rdata = s.wctrl;
        bmon_pkg::OFS_WIRE_STAT: d.rdata = {20'h00000, wire_status(s)};
        bmon_pkg::OFS_WIRE_RAW: d.rdata = {29'h0, s.wraw};
        bmon_pkg::OFS_WIRE_MASKED: d.rdata = {29'h0, wmasked};
        bmon_pkg::OFS_WIRE_IEN: d.rdata = {29'h0, s.wien};
        bmon_pkg::OFS_WIRE_BIT: d.rdata = s.wbit;
        bmon_pkg::OFS_WIRE_BRK: d.rdata = s.wbrk;
        bmon_pkg::OFS_BB_DATA: d.rdata = {24'h000000, rx_head};
        bmon_pkg::OFS_BB_CTRL: d.rdata = s.bctrl;
        bmon_pkg::OFS_BB_COUNT: d.rdata = s.bcount;
        bmon_pkg::OFS_BB_STAT: d.rdata = {16'h0000, 8'(tx_count), 8'(rx_count)};
        bmon_pkg::OFS_BB_RAW: d.rdata = {24'h000000, braw_full};
        bmon_pkg::OFS_BB_MASKED: d.rdata = {24'h000000, bmasked};
        bmon_pkg::OFS_BB_IEN: d.rdata = {24'h000000, s.bien};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  function automatic logic [31:0] lowmask(input logic [5:0] n);
    return (n >= 6'h20) ? 32'hFFFF_FFFF : (32'h0000_0001 << n) - 32'h0000_0001;
  endfunction

  function automatic bmon_pkg::wire_status_type wire_status(input bmon_pkg::core_state_type c);
    bmon_pkg::wire_status_type r;
    r.col = c.col;
    r.tef = c.tef;
    r.rxb = c.rx_mode && c.phase != bmon_pkg::W_IDLE;
    r.brf = c.brf;
    r.brs = c.phase == bmon_pkg::W_RECOVER;
    r.bks = c.phase == bmon_pkg::W_BREAK;
    r.rxf = c.rxf;
    r.txf = c.txf;
    r.pbs = c.phase == bmon_pkg::W_STOP;
    r.dbs = c.phase == bmon_pkg::W_DATA;
    r.sbs = c.phase == bmon_pkg::W_START;
    r.txb = !c.rx_mode && (r.pbs || r.dbs || r.sbs);
    return r;
  endfunction

  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s <= '0;
      s.wctrl <= bmon_pkg::WIRE_CTRL_RST;
      s.line_sync <= 3'h7;
      s.clk_sync <= 2'h3;
      s.out_lvl <= 1'b1;
    end else begin
      s <= d;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_core_n);

  a_wire_masked: assert property (reg_req.rd && at(reg_req, bmon_pkg::OFS_WIRE_MASKED)
    |=> reg_rdata[2:0] == ($past(s.wraw) & $past(s.wien))) else $error("wire masked status wrong");
  // The line must agree with the masked status that software reads back.
  a_combined_irq: assert property (reg_req.rd && at(reg_req, bmon_pkg::OFS_BB_MASKED)
    |=> (|reg_rdata) == $past(combined_irq_out)) else $error("combined interrupt mismatch");
  a_eoi_clear: assert property (reg_req.wr && at(reg_req, bmon_pkg::OFS_BB_RAW) && reg_req.wdata[2]
    && !arb_loss_pulse |=> !s.braw[bmon_pkg::BIRQ_ARB]) else $error("end of interrupt did not clear");
  a_break_done: assert property (s.phase == bmon_pkg::W_RECOVER && tick
    && s.partcnt == s.wbrk[31:16] && s.wctrl[bmon_pkg::POS_ENABLE] && !s.wctrl[bmon_pkg::POS_ABORT]
    |=> s.wraw[bmon_pkg::WIRQ_BREAK] && s.brf)
    else $error("break done not raised");
  a_word_in_clear: assert property (reg_req.rd && at(reg_req, bmon_pkg::OFS_WIRE_DATA)
    && s.phase != bmon_pkg::W_STOP |=> !s.wraw[bmon_pkg::WIRQ_WORD_IN]) else $error("data read kept word in");
  a_clk_low: assert property (!s.clk_sync[1] && s.low_cnt == 20'(CLK_LOW_CYCLES - 1)
    |=> s.braw[bmon_pkg::BIRQ_CLK_LOW]) else $error("clock low timeout missed");
  a_ack_flush: assert property (missing_ack_pulse
    |=> s.braw[bmon_pkg::BIRQ_ACK] && rx_empty && tx_empty) else $error("missing ack did not flush");
  a_stop_sent: assert property ($rose(s.braw[bmon_pkg::BIRQ_INIT]) |-> $past(stop_sent_pulse))
    else $error("initiator done without stop");
  a_tx_refused: assert property (reg_req.wr && at(reg_req, bmon_pkg::OFS_WIRE_DATA)
    && s.phase != bmon_pkg::W_IDLE |=> s.tef && s.wdata == $past(s.wdata)) else $error("busy write not refused");
  a_abort_idle: assert property (s.wctrl[bmon_pkg::POS_ABORT] |=> s.phase == bmon_pkg::W_IDLE
    && !s.wctrl[bmon_pkg::POS_ABORT]) else $error("abort left engine running");
  // A control write in the same cycle may enable the engine, so it is left out.
  a_disabled_idle: assert property (!s.wctrl[bmon_pkg::POS_ENABLE]
    && !(reg_req.wr && at(reg_req, bmon_pkg::OFS_WIRE_CTRL)) |=> s.phase == bmon_pkg::W_IDLE [*2])
    else $error("disabled engine active");

  c_word_out: cover property (s.phase == bmon_pkg::W_STOP ##1 s.wraw[bmon_pkg::WIRQ_WORD_OUT]);
  c_word_in: cover property ($rose(s.wraw[bmon_pkg::WIRQ_WORD_IN]));
  c_break: cover property (s.phase == bmon_pkg::W_BREAK ##[1:1000] s.phase == bmon_pkg::W_RECOVER);
  c_timeout: cover property ($rose(s.braw[bmon_pkg::BIRQ_RX_TO]));
endmodule

// ==== core/bmon_pkg.sv ====
package bmon_pkg;
  // Register offsets; each end-of-interrupt shares the address of its raw status.
  localparam logic [7:0] OFS_WIRE_DATA = 8'h00;
  localparam logic [7:0] OFS_WIRE_CTRL = 8'h04;
  localparam logic [7:0] OFS_WIRE_STAT = 8'h08;
  localparam logic [7:0] OFS_WIRE_RAW = 8'h0C;
  localparam logic [7:0] OFS_WIRE_MASKED = 8'h10;
  localparam logic [7:0] OFS_WIRE_IEN = 8'h14;
  localparam logic [7:0] OFS_WIRE_BIT = 8'h18;
  localparam logic [7:0] OFS_WIRE_BRK = 8'h1C;
  localparam logic [7:0] OFS_BB_DATA = 8'h40;
  localparam logic [7:0] OFS_BB_CTRL = 8'h44;
  localparam logic [7:0] OFS_BB_COUNT = 8'h48;
  localparam logic [7:0] OFS_BB_STAT = 8'h4C;
  localparam logic [7:0] OFS_BB_RAW = 8'h50;
  localparam logic [7:0] OFS_BB_MASKED = 8'h54;
  localparam logic [7:0] OFS_BB_IEN = 8'h58;

  // Wire control fields.
  localparam int POS_ENABLE = 0;
  localparam int POS_BREAK = 1;
  localparam int POS_FLIP = 2;
  localparam int POS_WLEN = 3;
  localparam int POS_RLEN = 9;
  localparam int POS_ABORT = 15;
  localparam int POS_POL = 16;
  localparam logic [31:0] WIRE_CTRL_RST = 32'h0000_0070;
  localparam logic [31:0] WIRE_CTRL_BITS = 32'h0001_FFFF;

  // Wire interrupt bits.
  localparam int WIRQ_WORD_OUT = 0;
  localparam int WIRQ_WORD_IN = 1;
  localparam int WIRQ_BREAK = 2;

  // Battery bus interrupt bits.
  localparam int BIRQ_CLK_LOW = 0;
  localparam int BIRQ_TARGET = 1;
  localparam int BIRQ_ARB = 2;
  localparam int BIRQ_ACK = 3;
  localparam int BIRQ_INIT = 4;
  localparam int BIRQ_RX_TO = 5;
  localparam int BIRQ_RX_LVL = 6;
  localparam int BIRQ_TX_LVL = 7;
  localparam logic [4:0] BIRQ_EOI_BITS = 5'h1F;

  // Battery bus control fields.
  localparam int BB_POS_FIFO_EN = 0;
  localparam int BB_POS_TIMEOUT = 8;

  // Timing.
  localparam int SYS_HZ = 20000000;
  localparam int REF_HZ = 7372800;
  localparam int CLK_LOW_MS = 25;
  localparam int CLK_LOW_CYCLES = (SYS_HZ / 1000) * CLK_LOW_MS;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic col;
    logic tef;
    logic rxb;
    logic brf;
    logic brs;
    logic bks;
    logic rxf;
    logic txf;
    logic pbs;
    logic dbs;
    logic sbs;
    logic txb;
  } wire_status_type;

  typedef enum logic [2:0] {W_IDLE, W_START, W_DATA, W_STOP, W_BREAK, W_RECOVER} wire_phase_type;

  typedef struct packed {
    logic [2:0] line_sync;
    logic [1:0] clk_sync;
    logic [31:0] wdata;
    logic [31:0] wctrl;
    logic [31:0] wbit;
    logic [31:0] wbrk;
    logic [31:0] shift;
    logic [2:0] wraw;
    logic [2:0] wien;
    logic col;
    logic tef;
    logic brf;
    logic rxf;
    logic txf;
    logic rx_mode;
    wire_phase_type phase;
    logic [5:0] bitcnt;
    logic [15:0] partcnt;
    logic out_lvl;
    logic out_en;
    logic [31:0] bctrl;
    logic [31:0] bcount;
    logic [5:0] braw;
    logic [7:0] bien;
    logic to_run;
    logic [15:0] to_cnt;
    logic [19:0] low_cnt;
    logic [31:0] rdata;
  } core_state_type;
endpackage

// ==== core/ref_tick_gen.sv ====
`timescale 1ns/1ps
// Fractional divider: average tick rate equals the reference rate, jitter one cycle.
module ref_tick_gen #(
  parameter int SYS_HZ = bmon_pkg::SYS_HZ,
  parameter int REF_HZ = bmon_pkg::REF_HZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Tick
  output logic tick
);
  if (REF_HZ <= 0 || REF_HZ >= SYS_HZ) begin : g_bad
    $error("ref_tick_gen: reference rate must lie below the system rate");
  end
  logic [31:0] acc_q;
  logic [31:0] sum;
  assign sum = acc_q + 32'(REF_HZ);
  assign tick = sum >= 32'(SYS_HZ);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 32'h0000_0000;
    end else begin
      acc_q <= tick ? sum - 32'(SYS_HZ) : sum;
    end
  end
endmodule

// ==== core/byte_fifo.sv ====
`timescale 1ns/1ps
// Head word is registered so that a read strobe sees settled data.
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic flush,
  input wire logic single,
  // Fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  output logic full,
  // Drain side
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic empty,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("byte_fifo: depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [WIDTH-1:0] head_q;
  logic do_push;
  logic do_pop;
  assign empty = cnt_q == '0;
  // A disabled FIFO behaves as one location.
  assign full = single ? !empty : cnt_q == (AW + 1)'(DEPTH);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = head_q;
  assign count = cnt_q;
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wp_q] <= push_data;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      head_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= do_push ? wp_q + 1'b1 : wp_q;
      rp_q <= do_pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      if (do_push && (empty || (cnt_q == (AW + 1)'(1) && do_pop))) begin
        head_q <= push_data;
      end else if (do_pop) begin
        head_q <= mem[rp_q + 1'b1];
      end else begin
        head_q <= mem[rp_q];
      end
    end
  end
endmodule

// ==== tb/bm_model.sv ====
`timescale 1ns/1ps
// Far side of the single wire; the line idles high through its pull-up.
module bm_model (
  // Clock
  input wire logic sys_clk,
  // Pin
  input wire logic wire_out,
  input wire logic wire_oe,
  output logic wire_in
);
  logic peer_oe = 1'b0;
  logic peer_lvl = 1'b1;
  assign wire_in = wire_oe ? wire_out : (peer_oe ? peer_lvl : 1'b1);
  // Sends n bits LSB first at normal polarity; each part lasts part_cycles clocks.
  task automatic send(input logic [31:0] v, input int n, input int part_cycles);
    @(posedge sys_clk);
    peer_oe <= 1'b1;
    for (int i = 0; i < n; i++) begin
      peer_lvl <= 1'b0;
      repeat (part_cycles) @(posedge sys_clk);
      peer_lvl <= v[i];
      repeat (part_cycles) @(posedge sys_clk);
      peer_lvl <= 1'b1;
      repeat (part_cycles) @(posedge sys_clk);
    end
    peer_oe <= 1'b0;
  endtask
endmodule

// ==== tb/tb_battery_monitor_link.sv ====
`timescale 1ns/1ps
module tb_battery_monitor_link;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  bmon_pkg::reg_req_type req = '0;
  logic [31:0] rdat;
  logic [31:0] d;
  logic w_in, w_out, w_oe, irq, rxr, txv;
  logic [7:0] txb;
  logic bclk = 1'b1;
  logic rxv = 1'b0;
  logic [7:0] rxb = 8'h00;
  logic [3:0] ev = 4'h0;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  battery_monitor_link #(.CLK_LOW_CYCLES(20)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req),
    .reg_rdata(rdat), .wire_in(w_in), .wire_out(w_out), .wire_oe(w_oe), .bus_clk_in(bclk),
    .target_done_pulse(ev[0]), .arb_loss_pulse(ev[1]), .missing_ack_pulse(ev[2]), .stop_sent_pulse(ev[3]),
    .rx_valid(rxv), .rx_byte(rxb), .rx_ready(rxr), .tx_valid(txv), .tx_byte(txb), .tx_ready(1'b0),
    .combined_irq_out(irq));
  bm_model peer_u (.sys_clk(sys_clk), .wire_out(w_out), .wire_oe(w_oe), .wire_in(w_in));
  task automatic give_verdict;
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 v = rdat;
  endtask
  // Polls a raw status bit under a bounded count of reads.
  task automatic wait_bit(input int b);
    for (int i = 0; i < 300; i++) begin
      rd(bmon_pkg::OFS_WIRE_RAW, d);
      if (d[b] === 1'b1) break;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(bmon_pkg::OFS_WIRE_CTRL, d);
    chk("wire_control", bmon_pkg::WIRE_CTRL_RST, d);
    wr(bmon_pkg::OFS_BB_CTRL, 32'h0000_FF00);
    wr(bmon_pkg::OFS_BB_IEN, 32'h1F);
    // Raw bit 7 stays up: the single transmit location is empty.
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      ev[i] <= 1'b1;
      @(posedge sys_clk);
      ev[i] <= 1'b0;
      rd(bmon_pkg::OFS_BB_RAW, d);
      chk("bus_raw", 32'h80 | (32'h2 << i), d);
      rd(bmon_pkg::OFS_BB_MASKED, d);
      chk("bus_masked", 32'h2 << i, d);
      chk("irq_set", 32'h1, {31'h0, irq});
      wr(bmon_pkg::OFS_BB_RAW, 32'h2 << i);
      chk("irq_clear", 32'h0, {31'h0, irq});
    end
    bclk <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rd(bmon_pkg::OFS_BB_RAW, d);
    chk("clock_low", 32'h81, d);
    bclk <= 1'b1;
    wr(bmon_pkg::OFS_BB_RAW, 32'h1);
    @(posedge sys_clk);
    rxv <= 1'b1;
    rxb <= 8'hA5;
    @(posedge sys_clk);
    rxv <= 1'b0;
    #1 chk("rx_ready", 32'h0, {31'h0, rxr});
    // The timeout limit is 0xFF, so the flag rises 256 cycles after the push; this wait outlasts it.
    repeat (260) @(posedge sys_clk);
    rd(bmon_pkg::OFS_BB_RAW, d);
    chk("rx_level", 32'hE0, d);
    rd(bmon_pkg::OFS_BB_DATA, d);
    chk("bus_data", 32'hA5, d);
    rd(bmon_pkg::OFS_BB_RAW, d);
    chk("rx_drained", 32'h80, d);
    wr(bmon_pkg::OFS_BB_DATA, 32'h5A);
    chk("tx_byte", 32'h15A, {23'h0, txv, txb});
    rd(bmon_pkg::OFS_BB_RAW, d);
    chk("tx_level", 32'h0, d);
    @(posedge sys_clk);
    ev[2] <= 1'b1;
    @(posedge sys_clk);
    ev[2] <= 1'b0;
    rd(bmon_pkg::OFS_BB_RAW, d);
    chk("ack_flush", 32'h88, d);
    wr(bmon_pkg::OFS_BB_RAW, 32'h8);
    // A second data write lands while the first word is still shifting.
    wr(bmon_pkg::OFS_WIRE_CTRL, 32'h09);
    wr(bmon_pkg::OFS_WIRE_DATA, 32'h1);
    wr(bmon_pkg::OFS_WIRE_DATA, 32'h0);
    chk("wire_drive", 32'h1, {31'h0, w_oe});
    rd(bmon_pkg::OFS_WIRE_STAT, d);
    chk("tx_error", 32'h1, {31'h0, d[10]});
    wait_bit(bmon_pkg::WIRQ_WORD_OUT);
    chk("word_out", 32'h1, d);
    wr(bmon_pkg::OFS_WIRE_RAW, 32'h1);
    wr(bmon_pkg::OFS_WIRE_BRK, 32'h0001_0001);
    wr(bmon_pkg::OFS_WIRE_CTRL, 32'h0B);
    wait_bit(bmon_pkg::WIRQ_BREAK);
    chk("break_done", 32'h4, d);
    wr(bmon_pkg::OFS_WIRE_RAW, 32'h4);
    rd(bmon_pkg::OFS_WIRE_RAW, d);
    chk("wire_raw", 32'h0, d);
    wr(bmon_pkg::OFS_WIRE_BIT, 32'h14);
    wr(bmon_pkg::OFS_WIRE_IEN, 32'h2);
    wr(bmon_pkg::OFS_WIRE_CTRL, 32'h405);
    // Each part is 21 reference ticks, just under 57 system clocks.
    peer_u.send(32'h2, 2, 57);
    wait_bit(bmon_pkg::WIRQ_WORD_IN);
    chk("word_in", 32'h2, d);
    rd(bmon_pkg::OFS_WIRE_MASKED, d);
    chk("wire_masked", 32'h2, d);
    rd(bmon_pkg::OFS_WIRE_DATA, d);
    chk("wire_word", 32'h1, d);
    rd(bmon_pkg::OFS_WIRE_RAW, d);
    chk("word_in_clear", 32'h0, d);
    give_verdict();
  end
endmodule
